// ==== core/eix_ext_irq.sv ====
/*
 * eix_ext_irq: sense, pending and wake logic for eight external interrupt lines,
 * with a classic wishbone register slave.
 * Assumes i_clk runs in all sleep modes and stands in for the always-on detector;
 * the gated I/O clock is modelled by o_io_clk_run.
 */
// What this block does
// - pin activity triggers even when driven as output
// - each line senses falling, rising or low level
// - enabled low level asserts request while low
// - upper edges need running I/O clock
// - levels and lower edges detected without I/O clock
// - asynchronous conditions wake from every sleep mode
// - I/O clock stopped in all non-idle sleep
// - power-down level wake needs two watchdog samples
// - wake begins after the two-sample check
// - vanished level wakes without level request
// - start-up delay chosen by start-up fuses
// - selector 00 low, 01 any, 10 fall, 11 rise
// - upper edges found by comparing successive samples
// - pending set by edge, cleared by entry or one
// - pending reads zero in level mode
`timescale 1ns/1ps
module eix_ext_irq
  import eix_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register bus
  input wire eix_wb_req_t i_wb,
  output eix_wb_rsp_t o_wb,
  // pins and cpu side
  input wire logic [N_LINES-1:0] i_ext_irq_lines,
  input wire logic i_global_ie,
  input wire logic [N_LINES-1:0] i_handler_ack,
  output logic o_irq,
  output logic [N_LINES-1:0] o_irq_lines,
  // sleep controller side
  input wire logic i_sleep_enter,
  input wire eix_sleep_t i_sleep_mode,
  input wire logic [1:0] i_startup_time_fuses,
  output logic o_io_clk_run,
  output logic o_wake,
  output logic o_awake
);
  logic [N_LINES-1:0] pin_s1;
  logic [N_LINES-1:0] pin_s2;
  logic [N_LINES-1:0] pin_prev;
  logic [15:0] sense_cfg;
  logic [N_LINES-1:0] line_enable_mask;
  logic [N_LINES-1:0] pending_flag;
  logic [N_LINES-1:0] trig;
  logic [N_LINES-1:0] lvl_mode;
  logic [N_LINES-1:0] lvl_act;
  logic [N_LINES-1:0] clr;
  logic [N_LINES-1:0] next_pending;
  eix_state_t state;
  eix_state_t next_state;
  eix_sleep_t slp_mode;
  logic [5:0] wdt_cnt;
  logic wdt_tick;
  logic [1:0] lvl_hits;
  logic [11:0] start_cnt;
  logic [11:0] start_len;
  logic io_run;
  logic edge_wake;
  logic lvl_wake;
  logic wb_hit;
  logic wb_wr;

  // pin synchronisers; the output drive level never masks the pin
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_prev <= '1;
    end else begin
      pin_s1 <= i_ext_irq_lines;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  assign io_run = (state == ST_RUN) || (state == ST_SLEEP && slp_mode == SLP_IDLE);

  // sense decode per line
  always_comb begin
    trig = '0;
    lvl_mode = '0;
    lvl_act = '0;
    for (int i = 0; i < N_LINES; i++) begin
      case (sense_cfg[2*i +: 2])
        SENSE_LOW: begin
          lvl_mode[i] = 1'b1;
          lvl_act[i] = ~pin_s2[i];
        end
        SENSE_ANY: trig[i] = pin_s2[i] ^ pin_prev[i];
        SENSE_FALL: trig[i] = pin_prev[i] & ~pin_s2[i];
        SENSE_RISE: trig[i] = ~pin_prev[i] & pin_s2[i];
        default: trig[i] = 1'b0;
      endcase
      if (i >= N_LOWER && !io_run) begin
        trig[i] = 1'b0;
      end
    end
  end

  // wishbone classic slave, one wait state
  assign wb_hit = i_wb.cyc && i_wb.stb && !o_wb.ack;
  assign wb_wr = wb_hit && i_wb.we && i_wb.sel[0];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb <= '0;
    end else begin
      o_wb.ack <= wb_hit;
      o_wb.dat <= '0;
      if (wb_hit && !i_wb.we) begin
        case (i_wb.adr)
          REG_SENSE_LOWER: o_wb.dat <= {24'h000000, sense_cfg[7:0]};
          REG_SENSE_UPPER: o_wb.dat <= {24'h000000, sense_cfg[15:8]};
          REG_LINE_ENABLE: o_wb.dat <= {24'h000000, line_enable_mask};
          REG_PENDING: o_wb.dat <= {24'h000000, pending_flag};
          REG_STATUS: begin
            o_wb.dat <= {22'h0, io_run, state == ST_RUN, pin_s2};
          end
          default: o_wb.dat <= '0;
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sense_cfg <= {RST_SENSE, RST_SENSE};
      line_enable_mask <= RST_ENABLE;
    end else if (wb_wr) begin
      if (i_wb.adr == REG_SENSE_LOWER) begin
        sense_cfg[7:0] <= i_wb.dat[7:0];
      end
      if (i_wb.adr == REG_SENSE_UPPER) begin
        sense_cfg[15:8] <= i_wb.dat[7:0];
      end
      if (i_wb.adr == REG_LINE_ENABLE) begin
        line_enable_mask <= i_wb.dat[7:0];
      end
    end
  end

  // pending flags: set beats clear, level mode forces zero
  assign clr = i_handler_ack | ((wb_wr && i_wb.adr == REG_PENDING) ? i_wb.dat[7:0] : 8'h00);
  assign next_pending = (trig | (pending_flag & ~clr)) & ~lvl_mode;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pending_flag <= RST_PENDING;
    end else begin
      pending_flag <= next_pending;
    end
  end

  // requests to the cpu
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq_lines <= '0;
      o_irq <= 1'b0;
    end else begin
      o_irq_lines <= (pending_flag | lvl_act) & line_enable_mask & {N_LINES{i_global_ie}};
      o_irq <= i_global_ie && |((pending_flag | lvl_act) & line_enable_mask);
    end
  end

  // watchdog oscillator sample tick
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdt_cnt <= '0;
    end else if (wdt_tick) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + 6'h01;
    end
  end
  assign wdt_tick = (wdt_cnt == 6'(WDT_CYC - 1));

  assign edge_wake = i_global_ie && |(trig & line_enable_mask);
  assign lvl_wake = i_global_ie && |(lvl_act & line_enable_mask);

  // two consecutive watchdog samples of the level in power-down
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lvl_hits <= '0;
    end else if (state != ST_SLEEP) begin
      lvl_hits <= '0;
    end else if (wdt_tick) begin
      if (!lvl_wake) begin
        lvl_hits <= '0;
      end else if (lvl_hits != LEVEL_SAMPLES) begin
        lvl_hits <= lvl_hits + 2'h1;
      end
    end
  end

  always_comb begin
    case (i_startup_time_fuses)
      2'h0: start_len = 12'(STARTUP_CYC0);
      2'h1: start_len = 12'(STARTUP_CYC1);
      2'h2: start_len = 12'(STARTUP_CYC2);
      default: start_len = 12'(STARTUP_CYC3);
    endcase
  end

  // sleep and wake sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (i_sleep_enter) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (slp_mode == SLP_IDLE) begin
          if (edge_wake || lvl_wake) begin
            next_state = ST_RUN;
          end
        end else if (edge_wake) begin
          next_state = ST_START;
        end else if (slp_mode == SLP_POWER_DOWN) begin
          if (lvl_hits == LEVEL_SAMPLES) begin
            next_state = ST_START;
          end
        end else if (lvl_wake) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (start_cnt == 12'h000) begin
          next_state = ST_RUN; // wake regardless of level now
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_RUN;
      slp_mode <= SLP_IDLE;
      start_cnt <= '0;
    end else begin
      state <= next_state;
      if (state == ST_RUN && i_sleep_enter) begin
        slp_mode <= i_sleep_mode;
      end
      if (state == ST_SLEEP) begin
        start_cnt <= start_len - 12'h001;
      end else if (start_cnt != 12'h000) begin
        start_cnt <= start_cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= (state != ST_RUN) && (next_state == ST_RUN);
    end
  end

  assign o_awake = (state == ST_RUN);
  assign o_io_clk_run = io_run;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  AST_LEVEL_PEND_ZERO: assert property (lvl_mode[0] |=> !pending_flag[0])
    else $error("pending set on level line");
  AST_LEVEL_REQ: assert property (lvl_act[1] && line_enable_mask[1] && i_global_ie |=> o_irq && o_irq_lines[1])
    else $error("level request missing");
  AST_UPPER_STOPPED: assert property (!io_run && !pending_flag[4] |=> !pending_flag[4])
    else $error("upper edge seen with clock stopped");
  AST_SET_WINS: assert property (trig[0] |=> pending_flag[0])
    else $error("edge lost");
  AST_CLEAR: assert property (clr[2] && !trig[2] |=> !pending_flag[2])
    else $error("pending not cleared");
  AST_GATE: assert property (!i_global_ie |=> !o_irq)
    else $error("irq without global enable");
  AST_IOCLK_OFF: assert property (state == ST_SLEEP && slp_mode != SLP_IDLE |-> !o_io_clk_run)
    else $error("io clock running in deep sleep");
  AST_PD_TWO: assert property (state == ST_SLEEP && slp_mode == SLP_POWER_DOWN && !edge_wake
    && lvl_hits != LEVEL_SAMPLES |=> state != ST_START)
    else $error("power-down level wake too early");
  // fuse setting 1 gives a 200-cycle start-up: still asleep on its last cycle, awake on the next
  AST_STARTUP: assert property ($rose(state == ST_START) && i_startup_time_fuses == 2'h1 |->
    ##199 !o_awake ##1 o_awake)
    else $error("start-up length wrong");
  AST_LOWER_ASYNC: assert property (state == ST_SLEEP && slp_mode == SLP_POWER_DOWN && trig[0]
    && line_enable_mask[0] && i_global_ie |=> state == ST_START)
    else $error("lower edge did not wake");

  COV_PD_LEVEL: cover property (state == ST_SLEEP && slp_mode == SLP_POWER_DOWN && lvl_hits == LEVEL_SAMPLES);
  COV_LOWER_EDGE: cover property (trig[0] && state == ST_SLEEP);
  COV_UPPER_EDGE: cover property (trig[7] ##1 pending_flag[7]);
endmodule : eix_ext_irq

// ==== core/eix_pkg.sv ====
/*
 * eix_pkg: constants and types for the external pin interrupt block.
 * Assumes a 50 MHz system clock that keeps running in every sleep mode.
 */
package eix_pkg;
  localparam int N_LINES = 8;
  localparam int N_LOWER = 4;

  // two-bit sense selector codes
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // wishbone byte offsets
  localparam logic [7:0] REG_SENSE_LOWER = 8'h00;
  localparam logic [7:0] REG_SENSE_UPPER = 8'h04;
  localparam logic [7:0] REG_LINE_ENABLE = 8'h08;
  localparam logic [7:0] REG_PENDING = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // status register fields
  localparam int STAT_PIN_LSB = 0;
  localparam int STAT_AWAKE_BIT = 8;
  localparam int STAT_IO_RUN_BIT = 9;

  // reset values
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PENDING = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_CYC = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] LEVEL_SAMPLES = 2'h2;
  localparam int STARTUP_US0 = 1;
  localparam int STARTUP_US1 = 4;
  localparam int STARTUP_US2 = 16;
  localparam int STARTUP_US3 = 64;
  localparam int STARTUP_CYC0 = (STARTUP_US0 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC1 = (STARTUP_US1 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC2 = (STARTUP_US2 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC3 = (STARTUP_US3 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SLP_IDLE = 2'h0,
    SLP_POWER_DOWN = 2'h1,
    SLP_OTHER = 2'h2
  } eix_sleep_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_SLEEP = 3'h2,
    ST_START = 3'h4
  } eix_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } eix_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } eix_wb_rsp_t;
endpackage : eix_pkg

// ==== test/eix_ext_irq_test.sv ====
/* eix_ext_irq_test: self-checking bench for the external pin interrupt block.
   Assumes the design package eix_pkg and the pin source model eix_pin_src. */
`timescale 1ns/1ps
module eix_ext_irq_test
  import eix_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  eix_wb_req_t req = '0;
  eix_wb_rsp_t rsp;
  logic [7:0] pins, hack = 8'h00, irql;
  logic ie = 1'b0, slp = 1'b0, irq, iorun, wake, awake;
  eix_sleep_t mode = SLP_IDLE;
  logic [1:0] fuses = 2'h0;
  int failures = 0, checks = 0, cyc_cnt = 0, n;
  logic [31:0] q;
  always #10 i_clk = ~i_clk;
  eix_pin_src src (.i_clk(i_clk), .o_lines(pins));
  eix_ext_irq dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb(req), .o_wb(rsp), .i_ext_irq_lines(pins),
    .i_global_ie(ie), .i_handler_ack(hack), .o_irq(irq), .o_irq_lines(irql), .i_sleep_enter(slp),
    .i_sleep_mode(mode), .i_startup_time_fuses(fuses), .o_io_clk_run(iorun), .o_wake(wake),
    .o_awake(awake));
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // classic cycle: request held until the rising edge that samples ack high, released right after it
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge i_clk);
    end while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask : wb
  task automatic sleep(input eix_sleep_t m);
    @(posedge i_clk);
    mode <= m;
    slp <= 1'b1;
    @(posedge i_clk);
    slp <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : sleep
  task automatic wait_awake(input int lim);
    n = 0;
    while (awake !== 1'b1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk("wake pulse", {31'h0, wake}, 32'h1);
    @(negedge i_clk);
    chk("wake drop", {31'h0, wake}, 32'h0);
  endtask : wait_awake
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      wb(1'b0, 8'(a * 4), 8'h00);
      chk("reset reg", q, (a == 4) ? 32'h3ff : 32'h0);
    end
    wb(1'b0, 8'h20, 8'h00);
    chk("unmapped", q, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, REG_SENSE_LOWER, 8'(c));
      wb(1'b1, REG_SENSE_UPPER, 8'(c));
      wb(1'b1, REG_PENDING, 8'hff);
      src.set(0, 1'b0);
      src.set(4, 1'b0);
      repeat (6) @(posedge i_clk);
      wb(1'b0, REG_PENDING, 8'h00);
      chk("pend fall", q, (c == 1 || c == 2) ? 32'h11 : 32'h0);
      wb(1'b1, REG_PENDING, 8'hff);
      src.set(0, 1'b1);
      src.set(4, 1'b1);
      repeat (6) @(posedge i_clk);
      wb(1'b0, REG_PENDING, 8'h00);
      chk("pend rise", q, (c == 1 || c == 3) ? 32'h11 : 32'h0);
    end
    wb(1'b1, REG_SENSE_LOWER, 8'h02);
    wb(1'b1, REG_PENDING, 8'hff);
    wb(1'b1, REG_LINE_ENABLE, 8'h03);
    src.set(1, 1'b0);
    repeat (6) @(posedge i_clk);
    chk("no global ie", {24'h0, irql}, 32'h0);
    @(posedge i_clk) ie <= 1'b1;
    repeat (30) @(posedge i_clk);
    chk("level held", {23'h0, irq, irql}, 32'h102);
    src.set(1, 1'b1);
    src.pulse(0, 1'b0, 3);
    repeat (6) @(posedge i_clk);
    chk("edge fwd", {24'h0, irql}, 32'h01);
    @(posedge i_clk) hack <= 8'h01;
    @(posedge i_clk) hack <= 8'h00;
    repeat (2) @(posedge i_clk);
    wb(1'b0, REG_PENDING, 8'h00);
    chk("handler clear", q, 32'h0);
    wb(1'b1, REG_SENSE_UPPER, 8'h02);
    wb(1'b1, REG_LINE_ENABLE, 8'h11);
    sleep(SLP_IDLE);
    chk("idle io clk", {31'h0, iorun}, 32'h1);
    src.pulse(4, 1'b0, 3);
    wait_awake(40);
    chk("idle wake", {31'h0, awake}, 32'h1);
    @(posedge i_clk) fuses <= 2'h1;
    wb(1'b1, REG_PENDING, 8'hff);
    sleep(SLP_POWER_DOWN);
    chk("pd io clk", {31'h0, iorun}, 32'h0);
    src.pulse(4, 1'b0, 4);
    repeat (10) @(posedge i_clk);
    chk("upper ignored", {31'h0, awake}, 32'h0);
    src.pulse(0, 1'b0, 3);
    wait_awake(600);
    chk("startup len", {31'h0, n >= STARTUP_CYC1 && n < STARTUP_CYC1 + 20}, 32'h1);
    wb(1'b0, REG_PENDING, 8'h00);
    chk("pd pend", q, 32'h01);
    wb(1'b1, REG_SENSE_LOWER, 8'h00);
    wb(1'b1, REG_LINE_ENABLE, 8'h04);
    sleep(SLP_POWER_DOWN);
    src.pulse(2, 1'b0, 30);
    repeat (100) @(posedge i_clk);
    chk("short level", {31'h0, awake}, 32'h0);
    src.pulse(2, 1'b0, 120);
    wait_awake(600);
    repeat (4) @(posedge i_clk);
    chk("vanished level", {30'h0, awake, irq}, 32'h2);
    sleep(SLP_POWER_DOWN);
    src.set(2, 1'b0);
    wait_awake(800);
    repeat (4) @(posedge i_clk);
    chk("held level", {23'h0, irq, irql}, 32'h104);
    src.set(2, 1'b1);
    repeat (3) @(posedge i_clk);
    sleep(SLP_OTHER);
    chk("other io clk", {31'h0, iorun}, 32'h0);
    src.pulse(2, 1'b0, 3);
    wait_awake(400);
    chk("other level wake", {31'h0, awake}, 32'h1);
    wrap_up();
  end
endmodule : eix_ext_irq_test

// ==== test/eix_pin_src.sv ====
/* eix_pin_src: behavioural sources driving the eight interrupt pins.
   Assumes pins idle high through a pull-up and that the bench calls its tasks. */
`timescale 1ns/1ps
module eix_pin_src (
  // clock
  input wire logic i_clk,
  // pins
  output logic [7:0] o_lines
);
  initial o_lines = 8'hff;
  // hold one line at lvl for n cycles, then let the pull-up return it high
  task automatic pulse(input int line, input logic lvl, input int n);
    @(posedge i_clk);
    o_lines[line] <= lvl;
    repeat (n) @(posedge i_clk);
    o_lines[line] <= 1'b1;
  endtask : pulse
  task automatic set(input int line, input logic lvl);
    @(posedge i_clk);
    o_lines[line] <= lvl;
  endtask : set
endmodule : eix_pin_src
